// file: dv/qpd_decoder_sva.sv
// concurrent checks on the decoder top ports
`timescale 1ns/100ps
`default_nettype none
module qpd_decoder_sva
  import qpd_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        quad_clock_out,
  input wire logic        direction_out,
  input wire logic        period_clock_out,
  input wire logic        index_occurrence_out,
  input wire logic        index_revolution_out,
  input wire logic        sync_start_out
);
  logic dcm_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) dcm_q <= 1'b0;
    else if (ce && reg_wr && reg_addr == QPD_CTRL_OFS) dcm_q <= reg_wdata[QPD_CTRL_DCM_BIT];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  run_follow_a: assert property (ce && reg_wr && reg_addr == QPD_CTRL_OFS
    |=> sync_start_out == $past(reg_wdata[QPD_CTRL_RUN_BIT])) else $error("sync start wrong");
  quad_pulse_a: assert property (quad_clock_out |=> !quad_clock_out)
    else $error("quad clock longer than one cycle");
  period_step_a: assert property (period_clock_out |-> quad_clock_out)
    else $error("period tick without step");
  idle_quiet_a: assert property (!sync_start_out && !$past(sync_start_out)
    |-> !quad_clock_out) else $error("step while stopped");
  dir_on_step_a: assert property ($changed(direction_out) |-> quad_clock_out)
    else $error("direction moved without step");
  rev_pulse_a: assert property (index_revolution_out |=> !index_revolution_out)
    else $error("revolution pulse too long");
  occ_pulse_a: assert property (index_occurrence_out |=> !index_occurrence_out)
    else $error("occurrence pulse too long");
  dcm_period_a: assert property (dcm_q && $past(dcm_q, 4) |-> !period_clock_out)
    else $error("period tick in direction-count mode");
  dcm_index_a: assert property (dcm_q && $past(dcm_q, 4)
    |-> !index_occurrence_out && !index_revolution_out) else $error("index out in dcm");

  cover property (quad_clock_out && direction_out);
  cover property (quad_clock_out && !direction_out);
  cover property (index_revolution_out);
endmodule // qpd_decoder_sva
`default_nettype wire

// file: dv/qpd_encoder_model.sv
// behavioural rotary encoder driving the four selectable pin sources
`timescale 1ns/100ps
`default_nettype none
module qpd_encoder_model (
  input  wire logic       clk,
  output var  logic [3:0] phase_a_input,
  output var  logic [3:0] phase_b_input,
  output var  logic [3:0] index_input
);
  logic       a;
  logic       b;
  logic       z;
  int         src;
  int         st;
  logic [1:0] seq [4];

  initial begin
    a = 1'b0;
    b = 1'b0;
    z = 1'b0;
    src = 0;
    st = 0;
    seq = '{2'b00, 2'b10, 2'b11, 2'b01};
  end

  // unselected sources carry the inverse, so a wrong select shows up
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      phase_a_input[k] = (k == src) ? a : ~a;
      phase_b_input[k] = (k == src) ? b : ~b;
      index_input[k]   = (k == src) ? z : ~z;
    end
  end

  // each state held 6 clocks, above the 3 the decoder needs to see it
  task automatic hold();
    repeat (6) @(posedge clk);
  endtask

  task automatic move(input logic cw);
    st = cw ? (st + 1) % 4 : (st + 3) % 4;
    a <= seq[st][1];
    b <= seq[st][0];
    hold();
  endtask

  // both phases flip at once: a skipped state
  task automatic skip();
    st = (st + 2) % 4;
    a <= seq[st][1];
    b <= seq[st][0];
    hold();
  endtask

  task automatic mark();
    z <= 1'b1;
    hold();
    z <= 1'b0;
    hold();
  endtask

  task automatic dtick(input logic d);
    a <= 1'b0;
    b <= d;
    hold();
    a <= 1'b1;
    hold();
  endtask
endmodule // qpd_encoder_model
`default_nettype wire

// file: dv/test_quadrature_position_decoder.sv
// self-checking bench of the quadrature position decoder
`timescale 1ns/100ps
`default_nettype none
module test_quadrature_position_decoder
  import qpd_pkg::*;
;
  logic clk, arst_n, ce, reg_wr, reg_rd, qc, dr, pc, oc, rv, ss;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic [3:0]  pa, pb, pz;
  int error_cnt, cmp_count, cyc, nq, np, no, nr, q0, p0, o0, r0;
  int occ_exp [4] = '{0, 1, 2, 0};

  qpd_encoder_model enc (.clk, .phase_a_input(pa), .phase_b_input(pb), .index_input(pz));
  qpd_decoder uut (.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .phase_a_input(pa), .phase_b_input(pb), .index_input(pz), .quad_clock_out(qc),
    .direction_out(dr), .period_clock_out(pc), .index_occurrence_out(oc),
    .index_revolution_out(rv), .sync_start_out(ss));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    nq += (qc === 1'b1);
    np += (pc === 1'b1);
    no += (oc === 1'b1);
    nr += (rv === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // let the written register settle before any level check reads it
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask

  task automatic snap();
    repeat (4) @(posedge clk);
    q0 = nq; p0 = np; o0 = no; r0 = nr;
  endtask

  // deltas of the pulse counters since the last snapshot
  task automatic deltas(input int q, input int p, input int o, input int r);
    repeat (4) @(posedge clk);
    chk("quad", q, nq - q0);
    chk("period", p, np - p0);
    chk("occurrence", o, no - o0);
    chk("revolution", r, nr - r0);
  endtask

  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd(QPD_CTRL_OFS); chk("ctrl reset", 32'h0000_0000, rd_v);
    chk("sync idle", 32'h0000_0000, {31'h0, ss});
    wr(QPD_CTRL_OFS, 32'h0000_0009);
    chk("sync run", 32'h0000_0001, {31'h0, ss});
    snap();
    repeat (4) enc.move(1'b1);
    deltas(4, 2, 0, 0);
    chk("dir cw", 32'h0000_0001, {31'h0, dr});
    rd(QPD_POS_OFS); chk("pos up", 32'h0000_0004, rd_v);
    repeat (5) enc.move(1'b0);
    chk("dir ccw", 32'h0000_0000, {31'h0, dr});
    rd(QPD_POS_OFS); chk("pos down", 32'h0000_FFFF, rd_v);
    // a write while the clock enable is low must leave the count alone
    ce <= 1'b0;
    wr(QPD_POS_OFS, 32'h0000_1234);
    ce <= 1'b1;
    rd(QPD_POS_OFS); chk("pos frozen", 32'h0000_FFFF, rd_v);
    snap(); enc.mark(); deltas(0, 0, 1, 1);
    rd(QPD_REV_OFS); chk("rev down", 32'h0000_FFFF, rd_v);
    snap(); enc.mark(); deltas(0, 0, 1, 0);
    for (int m = 0; m < 4; m++) begin
      wr(QPD_CTRL_OFS, 32'h0000_0000);
      chk("sync stop", 32'h0000_0000, {31'h0, ss});
      wr(QPD_CTRL_OFS, 32'(m * 4 + 1));
      enc.move(1'b1);
      snap(); enc.mark(); enc.mark(); deltas(0, 0, occ_exp[m], 1);
    end
    snap(); enc.skip(); deltas(0, 0, 0, 0);
    rd(QPD_STATUS_OFS); chk("skip flag", 32'h0000_0001, {31'h0, rd_v[4]});
    wr(QPD_INSEL_OFS, 32'h0000_002A);
    enc.src = 2;
    wr(QPD_CTRL_OFS, 32'h0000_0009);
    snap(); repeat (4) enc.move(1'b1); enc.mark(); deltas(4, 2, 1, 1);
    wr(QPD_CTRL_OFS, 32'h0000_0003);
    snap(); repeat (3) enc.dtick(1'b1); enc.mark(); deltas(3, 0, 0, 0);
    chk("dcm dir up", 32'h0000_0001, {31'h0, dr});
    enc.dtick(1'b0);
    chk("dcm dir down", 32'h0000_0000, {31'h0, dr});
    rd(8'h20); chk("unmapped", 32'h0000_0000, rd_v);
    summarize();
  end
endmodule // test_quadrature_position_decoder

bind qpd_decoder qpd_decoder_sva u_sva (.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
  .quad_clock_out, .direction_out, .period_clock_out, .index_occurrence_out,
  .index_revolution_out, .sync_start_out);
`default_nettype wire

// file: logic/qpd_decoder.sv
// top level of the quadrature position decoder with its register port
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module qpd_decoder
  import qpd_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [31:0]          reg_rdata,
  input  wire logic [QPD_SRC_N-1:0] phase_a_input,
  input  wire logic [QPD_SRC_N-1:0] phase_b_input,
  input  wire logic [QPD_SRC_N-1:0] index_input,
  output var  logic                 quad_clock_out,
  output var  logic                 direction_out,
  output var  logic                 period_clock_out,
  output var  logic                 index_occurrence_out,
  output var  logic                 index_revolution_out,
  output var  logic                 sync_start_out
);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic                 run;
  logic                 direction_count_select;
  qpd_icm_t             index_condition_select;
  logic [QPD_SEL_W-1:0] sel_a;
  logic [QPD_SEL_W-1:0] sel_b;
  logic [QPD_SEL_W-1:0] sel_z;
  logic [QPD_CNT_W-1:0] pos_count;
  logic [QPD_CNT_W-1:0] rev_count;
  logic                 index_seen;
  logic                 skip_err;
  logic                 moved;
  logic                 z_prev;

  logic wr_ctrl;
  logic wr_insel;
  logic wr_status;
  logic wr_pos;
  logic wr_rev;
  assign wr_ctrl   = reg_wr & (reg_addr == QPD_CTRL_OFS);
  assign wr_insel  = reg_wr & (reg_addr == QPD_INSEL_OFS);
  assign wr_status = reg_wr & (reg_addr == QPD_STATUS_OFS);
  assign wr_pos    = reg_wr & (reg_addr == QPD_POS_OFS);
  assign wr_rev    = reg_wr & (reg_addr == QPD_REV_OFS);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run                    <= QPD_CTRL_RST[QPD_CTRL_RUN_BIT];
      direction_count_select <= QPD_CTRL_RST[QPD_CTRL_DCM_BIT];
      index_condition_select <= qpd_icm_t'(QPD_CTRL_RST[QPD_CTRL_ICM_LSB +: 2]);
    end else if (ce && wr_ctrl) begin
      run                    <= reg_wdata[QPD_CTRL_RUN_BIT];
      direction_count_select <= reg_wdata[QPD_CTRL_DCM_BIT];
      index_condition_select <= qpd_icm_t'(reg_wdata[QPD_CTRL_ICM_LSB +: 2]);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_a <= QPD_INSEL_RST[QPD_INSEL_A_LSB +: QPD_SEL_W];
      sel_b <= QPD_INSEL_RST[QPD_INSEL_B_LSB +: QPD_SEL_W];
      sel_z <= QPD_INSEL_RST[QPD_INSEL_Z_LSB +: QPD_SEL_W];
    end else if (ce && wr_insel) begin
      sel_a <= reg_wdata[QPD_INSEL_A_LSB +: QPD_SEL_W];
      sel_b <= reg_wdata[QPD_INSEL_B_LSB +: QPD_SEL_W];
      sel_z <= reg_wdata[QPD_INSEL_Z_LSB +: QPD_SEL_W];
    end
  end

  // ----------------------------------------------------------------
  // input synchronisation and source selection
  // ----------------------------------------------------------------
  // every source is synchronised so a select change never exposes a raw pin
  logic [QPD_SRC_N-1:0] a_s;
  logic [QPD_SRC_N-1:0] b_s;
  logic [QPD_SRC_N-1:0] z_s;

  qpd_sync #(
    .W (3*QPD_SRC_N)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .d      ({index_input, phase_b_input, phase_a_input}),
    .q      ({z_s, b_s, a_s})
  );

  logic phase_a_sel;
  logic phase_b_sel;
  logic index_sel;
  assign phase_a_sel = a_s[sel_a];
  assign phase_b_sel = b_s[sel_b];
  assign index_sel   = z_s[sel_z];

  // ----------------------------------------------------------------
  // phase decoding
  // ----------------------------------------------------------------
  qpd_step_if ev ();

  qpd_quad u_quad (
    .clk                    (clk),
    .arst_n                 (arst_n),
    .ce                     (ce),
    .run                    (run),
    .direction_count_select (direction_count_select),
    .phase_a                (phase_a_sel),
    .phase_b                (phase_b_sel),
    .ev                     (ev.src)
  );

  // ----------------------------------------------------------------
  // index handling
  // ----------------------------------------------------------------
  logic z_rise;
  logic next_occ;
  logic next_rev;
  logic next_index_seen;
  logic next_moved;
  logic next_skip_err;

  // index is meaningless in direction-count mode, so it is masked there
  assign z_rise = run & ~direction_count_select & index_sel & ~z_prev;

  always_comb begin
    unique case (index_condition_select)
      QPD_ICM_FIRST: next_occ = z_rise & ~index_seen;
      QPD_ICM_EVERY: next_occ = z_rise;
      default:       next_occ = 1'b0;
    endcase
  end

  // a second index edge without any shaft motion is jitter, not a revolution
  assign next_rev        = z_rise & moved;
  assign next_moved      = ev.step | (moved & ~next_rev);
  assign next_index_seen = run & (index_seen | z_rise);
  assign next_skip_err   = ev.skip | (skip_err & ~(wr_status & reg_wdata[QPD_STAT_SKIP_BIT]));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      z_prev     <= 1'b0;
      moved      <= 1'b0;
      index_seen <= 1'b0;
      skip_err   <= 1'b0;
    end else if (ce) begin
      z_prev     <= index_sel;
      moved      <= next_moved;
      index_seen <= next_index_seen;
      skip_err   <= next_skip_err;
    end
  end

  // ----------------------------------------------------------------
  // position and revolution counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_count <= QPD_CNT_RST;
    end else if (ce) begin
      if (wr_pos) begin
        pos_count <= reg_wdata[QPD_CNT_W-1:0];
      end else if (ev.step) begin
        pos_count <= ev.dir ? pos_count + 16'h0001 : pos_count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rev_count <= QPD_CNT_RST;
    end else if (ce) begin
      if (wr_rev) begin
        rev_count <= reg_wdata[QPD_CNT_W-1:0];
      end else if (index_revolution_out) begin
        rev_count <= ev.dir ? rev_count + 16'h0001 : rev_count - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      index_occurrence_out <= 1'b0;
      index_revolution_out <= 1'b0;
    end else if (ce) begin
      index_occurrence_out <= next_occ;
      index_revolution_out <= next_rev;
    end
  end

  assign quad_clock_out   = ev.step;
  assign direction_out    = ev.dir;
  assign period_clock_out = ev.period_tick;
  assign sync_start_out   = run;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] ctrl_view;
  logic [31:0] insel_view;
  logic [31:0] status_view;

  assign ctrl_view   = {28'h000_0000, index_condition_select, direction_count_select, run};
  assign insel_view  = {26'h000_0000, sel_z, sel_b, sel_a};
  assign status_view = {27'h000_0000, skip_err, index_seen, ev.phase, ev.dir};

  always_comb begin
    unique case (reg_addr)
      QPD_CTRL_OFS:   rd_mux = ctrl_view;
      QPD_INSEL_OFS:  rd_mux = insel_view;
      QPD_STATUS_OFS: rd_mux = status_view;
      QPD_POS_OFS:    rd_mux = {16'h0000, pos_count};
      QPD_REV_OFS:    rd_mux = {16'h0000, rev_count};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule // qpd_decoder
`default_nettype wire

// file: logic/qpd_pkg.sv
// shared constants and types of the quadrature position decoder
package qpd_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] QPD_CTRL_OFS   = 8'h00;
  localparam logic [7:0] QPD_INSEL_OFS  = 8'h04;
  localparam logic [7:0] QPD_STATUS_OFS = 8'h08;
  localparam logic [7:0] QPD_POS_OFS    = 8'h0C;
  localparam logic [7:0] QPD_REV_OFS    = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned QPD_CTRL_RUN_BIT  = 0;
  localparam int unsigned QPD_CTRL_DCM_BIT  = 1;
  localparam int unsigned QPD_CTRL_ICM_LSB  = 2;
  localparam int unsigned QPD_INSEL_A_LSB   = 0;
  localparam int unsigned QPD_INSEL_B_LSB   = 2;
  localparam int unsigned QPD_INSEL_Z_LSB   = 4;
  localparam int unsigned QPD_STAT_DIR_BIT  = 0;
  localparam int unsigned QPD_STAT_PH_LSB   = 1;
  localparam int unsigned QPD_STAT_IDX_BIT  = 3;
  localparam int unsigned QPD_STAT_SKIP_BIT = 4;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned QPD_SRC_N = 4;
  localparam int unsigned QPD_SEL_W = 2;
  localparam int unsigned QPD_CNT_W = 16;
  localparam logic [3:0]           QPD_CTRL_RST  = 4'h0;
  localparam logic [5:0]           QPD_INSEL_RST = 6'h00;
  localparam logic [QPD_CNT_W-1:0] QPD_CNT_RST   = 16'h0000;

  // index condition encodings
  typedef enum logic [1:0] {
    QPD_ICM_OFF,
    QPD_ICM_FIRST,
    QPD_ICM_EVERY,
    QPD_ICM_SPARE
  } qpd_icm_t;

endpackage

// file: logic/qpd_quad.sv
// phase decoder: quadrature and direction-count stepping
`timescale 1ns/100ps
`default_nettype none
module qpd_quad
  import qpd_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic run,
  input  wire logic direction_count_select,
  input  wire logic phase_a,
  input  wire logic phase_b,
  qpd_step_if.src   ev
);
  logic [1:0] prev_ab;
  logic [1:0] cur_ab;
  logic [1:0] diff_ab;
  logic [1:0] cw_next;
  logic       one_step;
  logic       two_step;
  logic       clk_rise;
  logic       next_step;
  logic       next_dir;
  logic       next_tick;

  // clockwise order with phase a leading: 00 -> 10 -> 11 -> 01 -> 00
  assign cur_ab   = {phase_a, phase_b};
  assign diff_ab  = cur_ab ^ prev_ab;
  assign cw_next  = {~prev_ab[0], prev_ab[1]};
  assign one_step = diff_ab[1] ^ diff_ab[0];
  assign two_step = diff_ab[1] & diff_ab[0];
  assign clk_rise = phase_a & ~prev_ab[1];

  assign next_step = run & (direction_count_select ? clk_rise : one_step);
  assign next_dir  = direction_count_select ? phase_b : (cur_ab == cw_next);
  // one tick per single-step phase a edge in quadrature mode: every a/b pair of steps gives one tick
  assign next_tick = run & ~direction_count_select & one_step & diff_ab[1];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_ab        <= 2'h0;
      ev.step        <= 1'b0;
      ev.dir         <= 1'b0;
      ev.period_tick <= 1'b0;
      ev.skip        <= 1'b0;
    end else if (ce) begin
      prev_ab        <= cur_ab;
      ev.step        <= next_step;
      ev.period_tick <= next_tick;
      ev.skip        <= run & ~direction_count_select & two_step;
      if (next_step) begin
        ev.dir <= next_dir;
      end
    end
  end

  assign ev.phase = prev_ab;
endmodule // qpd_quad
`default_nettype wire

// file: logic/qpd_step_if.sv
// step events passed from the phase decoder to the top level
`timescale 1ns/100ps
`default_nettype none
interface qpd_step_if;
  logic       step;
  logic       dir;
  logic       period_tick;
  logic       skip;
  logic [1:0] phase;
  modport src (output step, output dir, output period_tick, output skip, output phase);
  modport dst (input step, input dir, input period_tick, input skip, input phase);
endinterface
`default_nettype wire

// file: logic/qpd_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module qpd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // qpd_sync
`default_nettype wire
